// *** inc/fdg_regs.svh ***
// Constants for the floppy drive control glue
`ifndef FDG_REGS_SVH
`define FDG_REGS_SVH
`define FDG_BASE_ADDR      8'hf8
`define FDG_CTRL_OFFSET    8'h04
`define FDG_CMD_POS        0
`define FDG_CMD_W          3
`define FDG_CMD_FAST_STEP  3'h1
`define FDG_CMD_LATCH      3'h2
`define FDG_CMD_SOFT_RST   3'h0
`define FDG_HEAD4_MASK     8'h37
`define FDG_HEAD4_VAL      8'h02
`define FDG_BIT_DRIVE      4
`define FDG_BIT_RESET      3
`define FDG_BIT_SEL_HI     2
`define FDG_BIT_SEL_LO     1
`define FDG_LATCH_RESET    5'h00
`define FDG_STEP_NS        12000
`define FDG_CLK_NS         10
`define FDG_STEP_CYC       ((`FDG_STEP_NS + `FDG_CLK_NS - 1) / `FDG_CLK_NS)
`define FDG_INDEX_GAP_NS   400000000
`define FDG_INDEX_CYC      (`FDG_INDEX_GAP_NS / `FDG_CLK_NS)
`endif

// *** inc/fdg_pkg.sv ***
// Types for the floppy drive control glue
package fdg_pkg;
  typedef enum logic [1:0] {
    FDG_SHOT_IDLE,
    FDG_SHOT_RUN
  } fdg_shot_t;
endpackage : fdg_pkg

// *** verilog/fdg_one_shot.sv ***
// Retriggerable one-shot timer with synchronised trigger
`timescale 1ns/1ps
module fdg_one_shot
  import fdg_pkg::*;
#(
  parameter int unsigned CYCLES = 16,
  parameter bit          SYNC   = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic trig,
  output logic      pulse
);
  logic [2:0]  sync_r;
  logic        prev_r;
  logic [31:0] cnt_r;
  fdg_shot_t   state_r;
  wire         trig_s = SYNC ? ((sync_r[2] == sync_r[1]) ? sync_r[1] : prev_r)
                             : trig;
  wire         rise   = trig_s & ~prev_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_r  <= 3'h0;
      prev_r  <= 1'b0;
      cnt_r   <= 32'h0;
      state_r <= FDG_SHOT_IDLE;
    end else begin
      sync_r <= {sync_r[1:0], trig};
      prev_r <= trig_s;
      case (state_r)
        FDG_SHOT_IDLE: begin
          if (rise) begin
            cnt_r   <= CYCLES - 32'h1;
            state_r <= FDG_SHOT_RUN;
          end
        end
        FDG_SHOT_RUN: begin
          if (rise) begin
            cnt_r <= CYCLES - 32'h1;
          end else if (cnt_r == 32'h0) begin
            state_r <= FDG_SHOT_IDLE;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        default: state_r <= FDG_SHOT_IDLE;
      endcase
    end
  end

  assign pulse = (state_r == FDG_SHOT_RUN);
endmodule : fdg_one_shot

// *** verilog/fdg_glue.sv ***
// Floppy drive control glue top level
`timescale 1ns/1ps
`include "fdg_regs.svh"
// Overview of operation
// - Step lines low only when both gates high
// - Controller step fires 12 us high pulse
// - Step rate follows controller step output
// - Direction offered inverted and true
// - Write xx001 gives one-clock fast step
// - Pattern UU00U010 raises fourth head enable
// - Write xx010 latches data bit 4
// - Write xx000 gives one-clock low reset pulse
// - Inverted latch bit 3 as reset level
// - Reset line active on source or master low
// - Input select routes drive 0 or 1 status
// - Output latch bits 2, 1 inverted, 2 true
// - One-of-four decoder makes drive selects
// - Head loads gated commonly and per drive
// - Buffered head load high when loading
// - Controller refuses transfers unless ready high
// - Ready from drive or index one-shot
// - Stall host bus during transfers while ready is low
// - Inner-track polarity chosen by option
// - Control port at switch base plus four
module fdg_glue
  import fdg_pkg::*;
#(
  parameter int unsigned INDEX_CYCLES = `FDG_INDEX_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [4:0] base_switch,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_write,
  input  wire logic       ctrl_step,
  input  wire logic       step_direction,
  input  wire logic       ctrl_head_load,
  input  wire logic       ctrl_inner_track,
  input  wire logic       ctrl_transfer,
  input  wire logic       step_gate_out,
  input  wire logic       step_gate_in,
  input  wire logic       step_enable_out,
  input  wire logic       step_enable_in,
  input  wire logic       use_fast_step,
  input  wire logic       drive_sel_source,
  input  wire logic [1:0] reset_src_sel,
  input  wire logic       use_index_ready,
  input  wire logic       inner_track_low,
  input  wire logic       use_fourth_enable,
  input  wire logic       drive0_ready_n,
  input  wire logic       drive1_ready_n,
  input  wire logic       drive0_index_n,
  input  wire logic       drive1_index_n,
  input  wire logic       drive0_track0_n,
  input  wire logic       drive1_track0_n,
  input  wire logic       drive0_fault_n,
  input  wire logic       drive1_fault_n,
  input  wire logic       drive0_rdata_n,
  input  wire logic       drive1_rdata_n,
  output logic            step_out_n,
  output logic            step_in_n,
  output logic            step_pulse,
  output logic            dir_in_low,
  output logic            dir_in_high,
  output logic            fast_step_pulse,
  output logic            fourth_head_enable,
  output logic            latched_drive_bit,
  output logic            soft_reset_pulse_n,
  output logic            latched_reset_level,
  output logic            drive_reset_n,
  output logic            drive_input_select,
  output logic            sel_hi_n,
  output logic            sel_lo_n,
  output logic            sel_hi,
  output logic [3:0]      drive_select_n,
  output logic [3:0]      head_load_n,
  output logic            head_load,
  output logic            ctrl_ready,
  output logic            transfer_allowed,
  output logic            index_derived_ready,
  output logic            bus_wait_stall,
  output logic            inner_track_flag,
  output logic            sel_ready,
  output logic            sel_index,
  output logic            sel_track0,
  output logic            sel_fault,
  output logic            sel_rdata
);
  logic [4:0] latch_r;
  logic       fast_r;
  logic       head4_r;
  logic       srst_n_r;
  logic       step_shot;
  logic       index_shot;

  wire [7:0] ctrl_addr  = {base_switch, 3'h0} + `FDG_CTRL_OFFSET;
  wire       ctrl_hit   = io_write && (io_addr == ctrl_addr);
  wire [2:0] cmd        = io_wdata[`FDG_CMD_POS +: `FDG_CMD_W];
  wire       do_fast    = ctrl_hit && (cmd == `FDG_CMD_FAST_STEP);
  wire       do_latch   = ctrl_hit && (cmd == `FDG_CMD_LATCH);
  wire       do_srst    = ctrl_hit && (cmd == `FDG_CMD_SOFT_RST);
  wire       head4_hit  = ctrl_hit &&
    ((io_wdata & `FDG_HEAD4_MASK) == `FDG_HEAD4_VAL);
  wire       sel_index_raw = drive_input_select ? drive1_index_n
                                                : drive0_index_n;
  wire       sel_ready_n   = drive_input_select ? drive1_ready_n
                                                : drive0_ready_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_r  <= `FDG_LATCH_RESET;
      fast_r   <= 1'b0;
      head4_r  <= 1'b0;
      srst_n_r <= 1'b1;
    end else begin
      if (do_latch) begin
        latch_r <= io_wdata[4:0];
      end
      fast_r   <= do_fast;
      head4_r  <= head4_hit;
      srst_n_r <= ~do_srst;
    end
  end

  // Step one-shot; its rate comes from the controller's step output
  fdg_one_shot #(
    .CYCLES (`FDG_STEP_CYC),
    .SYNC   (1'b0)
  ) u_step_shot (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .trig    (ctrl_step),
    .pulse   (step_shot)
  );

  fdg_one_shot #(
    .CYCLES (INDEX_CYCLES),
    .SYNC   (1'b1)
  ) u_index_shot (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .trig    (~sel_index_raw),
    .pulse   (index_shot)
  );

  wire gate_step     = use_fast_step ? fast_r : step_shot;
  wire ready_src     = use_index_ready ? index_shot : ~sel_ready_n;
  wire [1:0] sel_code = {latch_r[`FDG_BIT_SEL_LO], ~latch_r[`FDG_BIT_SEL_HI]};
  wire rst_source;

  assign rst_source = (reset_src_sel == 2'h1) ? srst_n_r :
                      (reset_src_sel == 2'h2) ? ~latch_r[`FDG_BIT_RESET] :
                      1'b1;

  assign step_pulse          = step_shot;
  assign step_out_n = ~(step_gate_out & step_enable_out & gate_step &
                        ~step_direction);
  assign step_in_n  = ~(step_gate_in & step_enable_in & gate_step &
                        step_direction);
  assign dir_in_low          = ~step_direction;
  assign dir_in_high         = step_direction;
  assign fast_step_pulse     = fast_r;
  assign fourth_head_enable  = head4_r;
  assign latched_drive_bit   = latch_r[`FDG_BIT_DRIVE];
  assign soft_reset_pulse_n  = srst_n_r;
  assign latched_reset_level = ~latch_r[`FDG_BIT_RESET];
  assign drive_reset_n       = rst_source & reset_n;
  assign drive_input_select  = drive_sel_source & latched_drive_bit;
  assign sel_hi_n            = ~latch_r[`FDG_BIT_SEL_HI];
  assign sel_lo_n            = ~latch_r[`FDG_BIT_SEL_LO];
  assign sel_hi              = latch_r[`FDG_BIT_SEL_HI];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_drive
      wire pick = (sel_code == 2'(gi));
      wire qual = (gi == 3 && use_fourth_enable) ? head4_r : pick;
      assign drive_select_n[gi] = ~pick;
      assign head_load_n[gi]    = ~(ctrl_head_load & qual);
    end
  endgenerate

  assign head_load           = ctrl_head_load;
  assign ctrl_ready          = ready_src;
  assign transfer_allowed    = ctrl_transfer & ready_src;
  assign index_derived_ready = index_shot;
  assign bus_wait_stall      = ctrl_transfer & ~ready_src;
  assign inner_track_flag    = inner_track_low ? ~ctrl_inner_track
                                               : ctrl_inner_track;
  assign sel_ready           = ~sel_ready_n;
  assign sel_index           = ~sel_index_raw;
  assign sel_track0 = ~(drive_input_select ? drive1_track0_n
                                           : drive0_track0_n);
  assign sel_fault  = ~(drive_input_select ? drive1_fault_n
                                           : drive0_fault_n);
  assign sel_rdata  = ~(drive_input_select ? drive1_rdata_n
                                           : drive0_rdata_n);
endmodule : fdg_glue

// *** tb/fdg_glue_props.sv ***
// Property checker for the floppy drive control glue
`timescale 1ns/1ps
module fdg_glue_props (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [4:0] base_switch,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_write,
  input wire logic       step_direction,
  input wire logic       ctrl_transfer,
  input wire logic       ctrl_ready,
  input wire logic       fast_step_pulse,
  input wire logic       fourth_head_enable,
  input wire logic       soft_reset_pulse_n,
  input wire logic       latched_drive_bit,
  input wire logic       latched_reset_level,
  input wire logic       dir_in_low,
  input wire logic       bus_wait_stall
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire       hw = io_write && io_addr == {base_switch, 3'h4};
  wire [2:0] cw = io_wdata[2:0];
  wire       lw = hw && cw == 3'h2;
  a_fast_step: assert property (##1 fast_step_pulse ==
    $past(hw && cw == 3'h1)) else $error("fast step wrong");
  a_soft_reset: assert property (##1 soft_reset_pulse_n !=
    $past(hw && cw == 3'h0)) else $error("soft reset wrong");
  a_fourth_head: assert property (##1 fourth_head_enable ==
    $past(hw && (io_wdata & 8'h37) == 8'h02)) else $error("head4 wrong");
  a_drive_bit: assert property (lw |=> latched_drive_bit ==
    $past(io_wdata[4])) else $error("drive bit wrong");
  a_latch_hold: assert property (!lw |=> $stable(latched_drive_bit))
    else $error("drive bit moved");
  a_reset_level: assert property (lw |=> latched_reset_level !=
    $past(io_wdata[3])) else $error("reset level wrong");
  a_dir_pair: assert property (dir_in_low != step_direction)
    else $error("direction wrong");
  a_stall_when: assert property (bus_wait_stall ==
    (ctrl_transfer && !ctrl_ready)) else $error("bus stall wrong");
endmodule : fdg_glue_props
bind fdg_glue fdg_glue_props i_props (.*);

// *** tb/fdg_drive_model.sv ***
// Behavioural model of two drives on the ribbon cable
`timescale 1ns/1ps
module fdg_drive_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  output logic      [9:0] drv_n
);
  logic [4:0] cnt = 5'h00;
  initial drv_n = 10'h3ff;
  always @(posedge ref_clk) begin
    cnt <= cnt + 5'h01;
    drv_n <= {!reset_n, 1'b1, cnt > 5'h01, cnt[4:1] != 4'h8,
      6'($urandom)};
  end
endmodule : fdg_drive_model

// *** tb/fdg_glue_tb.sv ***
// Self-checking bench for the floppy drive control glue
`timescale 1ns/1ps
module fdg_glue_tb;
  logic ref_clk = 0, reset_n = 0, io_write = 0, ctrl_step = 0;
  logic pz = 0, wr_d = 0, rt, fs = 0, h4 = 0, rdy;
  logic [3:0] hl;
  logic [12:0] opt = 13'h0000;
  logic [1:0] reset_src_sel = 2'h2;
  logic [4:0] base_switch = 5'h1f, lat = 5'h00;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, notes[$];
  wire [9:0] drv_n;
  wire step_gate_out = opt[0], step_gate_in = opt[1], step_enable_out = opt[2];
  wire step_enable_in = opt[3], use_fast_step = opt[4];
  wire step_direction = opt[5], ctrl_head_load = opt[6];
  wire ctrl_inner_track = opt[7], ctrl_transfer = opt[8];
  wire drive_sel_source = opt[9], use_index_ready = opt[10];
  wire inner_track_low = opt[11], use_fourth_enable = opt[12];
  wire drive0_ready_n = drv_n[9], drive1_ready_n = drv_n[8];
  wire drive0_index_n = drv_n[7], drive1_index_n = drv_n[6];
  wire drive0_track0_n = drv_n[5], drive1_track0_n = drv_n[4];
  wire drive0_fault_n = drv_n[3], drive1_fault_n = drv_n[2];
  wire drive0_rdata_n = drv_n[1], drive1_rdata_n = drv_n[0];
  wire step_out_n, step_in_n, step_pulse, dir_in_low, dir_in_high;
  wire fast_step_pulse, fourth_head_enable, latched_drive_bit;
  wire soft_reset_pulse_n, latched_reset_level, drive_reset_n, sel_hi;
  wire drive_input_select, sel_hi_n, sel_lo_n, head_load, ctrl_ready;
  wire transfer_allowed, index_derived_ready, bus_wait_stall, sel_rdata;
  wire inner_track_flag, sel_ready, sel_index, sel_track0, sel_fault;
  wire [3:0] drive_select_n, head_load_n;
  int mismatches = 0, comparisons = 0, cycles = 0, n;
  fdg_glue #(.INDEX_CYCLES(50)) i_dut (.*);
  fdg_drive_model i_drive (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic check(string s, logic [11:0] seen, logic [11:0] exp);
    comparisons++;
    if (seen !== exp) $display("BAD %s exp %h seen %h", s, exp, seen);
    if (seen !== exp) mismatches++;
  endtask : check
  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic put(logic w, logic [7:0] a, logic [7:0] d);
    logic hit;
    hit = w && a == {base_switch, 3'h4};
    pz = hit && d[2:0] == 3'h0;
    fs = hit && d[2:0] == 3'h1;
    h4 = hit && (d & 8'h37) == 8'h02;
    if (hit && d[2:0] == 3'h2) lat = d[4:0];
    if (w) notes.push_back({hit && d[2:0] == 3'h1, hit && (d & 8'h37) == 8'h02,
      !pz, lat[4], !lat[3], !lat[2], !lat[1], lat[2]});
    {io_write, io_addr, io_wdata} = {w, a, d};
    @(negedge ref_clk);
  endtask : put
  always @(posedge ref_clk) begin
    wr_d <= io_write;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(negedge ref_clk)
    if (wr_d) check("wr", {fast_step_pulse, fourth_head_enable,
      soft_reset_pulse_n, latched_drive_bit, latched_reset_level, sel_hi_n,
      sel_lo_n, sel_hi}, notes.pop_front());
  initial begin
    void'($urandom(83254));
    repeat (5) @(negedge ref_clk);
    check("rsel", drive_select_n, 4'hd);
    check("rline", drive_reset_n, 1'b0);
    reset_n = 1;
    @(negedge ref_clk);
    repeat (300) begin
      rt = opt[9] & lat[4];
      check("isel", drive_input_select, rt);
      check("trk", sel_track0, !(rt ? drive1_track0_n : drive0_track0_n));
      check("inner", inner_track_flag, opt[7] ^ opt[11]);
      check("dsel", drive_select_n, 4'(~(4'h1 << {lat[1], !lat[2]})));
      check("drst", drive_reset_n, reset_src_sel == 2'h2 ? !lat[3] :
        reset_src_sel == 2'h1 ? !pz : 1'b1);
      rdy = !(rt ? drive1_ready_n : drive0_ready_n);
      check("sts", {sel_ready, sel_index, sel_fault, sel_rdata},
        4'(~(rt ? {drive1_ready_n, drive1_index_n, drive1_fault_n,
        drive1_rdata_n} : {drive0_ready_n, drive0_index_n, drive0_fault_n,
        drive0_rdata_n})));
      hl = 4'h1 << {lat[1], !lat[2]};
      if (opt[12]) hl[3] = h4;
      check("hld", head_load_n, 4'(~({4{opt[6]}} & hl)));
      check("hl", {head_load, dir_in_high}, {opt[6], opt[5]});
      if (!opt[10]) check("rdy", {ctrl_ready, transfer_allowed,
        bus_wait_stall}, {rdy, opt[8] & rdy, opt[8] & !rdy});
      if (opt[4]) check("fstep", {step_out_n, step_in_n},
        {!(opt[0] & opt[2] & fs & !opt[5]),
        !(opt[1] & opt[3] & fs & opt[5])});
      opt = 13'($urandom);
      {reset_src_sel, ctrl_step} = 3'($urandom);
      base_switch = $urandom % 3 ? 5'h1f : 5'($urandom);
      put($urandom % 4 != 0, $urandom % 2 ? {base_switch, 3'h4} : 8'($urandom),
        8'($urandom));
    end
    {io_write, ctrl_step, opt} = {2'b00, 13'h000f};
    for (n = 0; n < 1300 && step_pulse !== 1'b0; n++) @(negedge ref_clk);
    ctrl_step = 1;
    for (n = 0; n < 3 && step_pulse !== 1'b1; n++) @(negedge ref_clk);
    check("step", {step_out_n, step_in_n}, 2'b01);
    for (n = 0; n < 1300 && step_pulse === 1'b1; n++) @(negedge ref_clk);
    check("width", n[11:0], 12'd1200);
    opt = 13'h0500;
    @(negedge ref_clk);
    check("iready", {index_derived_ready, ctrl_ready, transfer_allowed,
      bus_wait_stall}, 4'he);
    finish_test();
  end
endmodule : fdg_glue_tb
